// file: ctd_trap_dispatch.sv
// trap dispatch unit: picks one trap, aborts, saves pc, writes id, redirects; underflow skips save and id write
module ctd_trap_dispatch
  import ctd_pkg::*;
#(
  parameter int PC_W = 32,
  parameter int PRIO_W = 8
) (
  input wire logic clk, // 25 MHz cpu clock
  input wire logic rst_n, // async reset, active low
  input wire ctd_sync_t sync_trap_i, // instruction-side trap conditions
  input wire logic [PC_W-1:0] faulting_instr_pc_i, // pc of instruction in progress
  input wire logic [PC_W-1:0] following_instr_pc_i, // pc of next instruction
  input wire logic service_call_trap_i, // syscall executing
  input wire logic [7:0] service_call_imm_i, // syscall immediate
  input wire logic nmi_ext_i, // external non-maskable pulse
  input wire logic watchdog_i, // watchdog expiry pulse
  input wire logic clk_loss_i, // clock generator lost lock pulse
  input wire logic store_bus_error_trap_i, // store bus error pulse
  input wire logic [PC_W-1:0] store_err_pc_i, // pc of erring store
  input wire logic [PC_W-1:0] trap_vec_base_i, // trap vector table base
  input wire logic [PC_W-1:0] uflow_handler_pc_i, // dedicated underflow handler
  input wire logic [PRIO_W-1:0] current_priority_field_i, // live cpu priority
  output logic trap_abort_o, // abort instruction in progress
  output ctd_cause_t trap_cause_o, // class and id of delivered trap
  output logic ctx_save_o, // save context with return pc
  output logic [PC_W-1:0] saved_pc_o, // return pc
  output logic id_reg_we_o, // write trap_id_data_register
  output logic [31:0] id_reg_data_o, // value for trap_id_data_register
  output logic redirect_o, // fetch from handler_pc_o
  output logic [PC_W-1:0] handler_pc_o, // handler entry address
  output logic uflow_direct_o, // redirect is the direct underflow jump
  output logic busy_o, // entry sequence running
  output logic [PRIO_W-1:0] current_priority_field_o // priority seen by handler
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_q;
  logic rst_sync_n;

  // two-stage release, assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending asynchronous sources

  logic [CTD_NUM_ASYNC-1:0] async_in;
  logic [CTD_NUM_ASYNC-1:0] pend_q;
  logic [CTD_NUM_ASYNC-1:0] pend_d;
  logic [CTD_NUM_ASYNC-1:0] pend_clr;
  logic [PC_W-1:0] store_pc_q;
  logic [PC_W-1:0] store_pc_d;
  logic take;
  logic [CTD_SEL_W-1:0] sel;

  assign async_in[CTD_AS_NMI_EXT] = nmi_ext_i;
  assign async_in[CTD_AS_WATCHDOG] = watchdog_i;
  assign async_in[CTD_AS_CLK_LOSS] = clk_loss_i;
  assign async_in[CTD_AS_STORE] = store_bus_error_trap_i;

  // one delivery covers all three non-maskable sources
  assign pend_clr[CTD_AS_NMI_EXT] = take && (sel == CTD_SLOT_NMI);
  assign pend_clr[CTD_AS_WATCHDOG] = take && (sel == CTD_SLOT_NMI);
  assign pend_clr[CTD_AS_CLK_LOSS] = take && (sel == CTD_SLOT_NMI);
  assign pend_clr[CTD_AS_STORE] = take && (sel == CTD_SLOT_STORE);

  // outside events are held until delivered; a new event beats the clear
  genvar gi;
  generate
    for (gi = 0; gi < CTD_NUM_ASYNC; gi++) begin : g_pend
      always_comb begin
        pend_d[gi] = async_in[gi] || (pend_q[gi] && !pend_clr[gi]);
      end
    end
  endgenerate

  // no queue: a second store error before delivery overwrites the pc
  always_comb begin
    store_pc_d = store_bus_error_trap_i ? store_err_pc_i : store_pc_q;
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pend_q <= '0;
      store_pc_q <= '0;
    end else begin
      pend_q <= pend_d;
      store_pc_q <= store_pc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source vector and fixed priority

  logic [CTD_NUM_SRC-1:0] src_vec;
  logic any_src;
  ctd_state_t state_q;
  ctd_state_t state_d;

  // slot order: nmi, store, sync conditions bit 0 upward, syscall last
  assign src_vec = {service_call_trap_i, sync_trap_i, pend_q[CTD_AS_STORE],
                    |pend_q[CTD_AS_CLK_LOSS:CTD_AS_NMI_EXT]};
  assign any_src = |src_vec;

  // lowest slot wins; walking downward leaves the lowest set slot
  always_comb begin
    sel = '0;
    for (int i = CTD_NUM_SRC - 1; i >= 0; i--) begin
      if (src_vec[i]) begin
        sel = CTD_SEL_W'(i);
      end
    end
  end

  // no enable, mask or disable term exists on this path
  assign take = (state_q == CTD_ST_IDLE) && any_src;
  assign trap_abort_o = take;

  ////////////////////////////////////////////////////////////////////////////
  // cause, return pc and handler address

  ctd_cause_t cause_q;
  ctd_cause_t cause_d;
  logic [PC_W-1:0] saved_pc_q;
  logic [PC_W-1:0] saved_pc_d;
  logic [PC_W-1:0] handler_pc_q;
  logic [PC_W-1:0] handler_pc_d;
  logic uflow_q;
  logic uflow_d;
  logic [PRIO_W-1:0] prio_q;
  logic [PRIO_W-1:0] prio_d;

  // table lookup gives class and id of each slot; syscall id from its immediate
  always_comb begin
    cause_d = cause_q;
    saved_pc_d = saved_pc_q;
    handler_pc_d = handler_pc_q;
    uflow_d = uflow_q;
    if (take) begin
      cause_d.trap_class_number = CTD_SRC_CLASS[sel];
      cause_d.trap_id_number = CTD_SRC_ID[sel];
      if (sel == CTD_SLOT_SYSCALL) begin
        cause_d.trap_id_number = service_call_imm_i;
      end
      // return pc: next for syscall and nmi, erring store pc, else faulting pc
      if (sel == CTD_SLOT_SYSCALL || sel == CTD_SLOT_NMI) begin
        saved_pc_d = following_instr_pc_i;
      end else if (sel == CTD_SLOT_STORE) begin
        saved_pc_d = store_pc_q;
      end else begin
        saved_pc_d = faulting_instr_pc_i;
      end
      uflow_d = (sel == CTD_SLOT_UFLOW);
      if (sel == CTD_SLOT_UFLOW) begin
        handler_pc_d = uflow_handler_pc_i;
      end else begin
        handler_pc_d = trap_vec_base_i +
          (PC_W'(CTD_SRC_CLASS[sel]) << CTD_VEC_SHIFT);
      end
    end
  end

  // priority is tracked only outside entry, never written by a trap
  always_comb begin
    prio_d = (state_q == CTD_ST_IDLE && !take) ? current_priority_field_i : prio_q;
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cause_q <= '{trap_class_number: CTD_CLASS_RESET, trap_id_number: CTD_ID_RESET};
      saved_pc_q <= '0;
      handler_pc_q <= '0;
      uflow_q <= 1'b0;
      prio_q <= '0;
    end else begin
      cause_q <= cause_d;
      saved_pc_q <= saved_pc_d;
      handler_pc_q <= handler_pc_d;
      uflow_q <= uflow_d;
      prio_q <= prio_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // entry sequencer

  // save, then id write, then redirect; underflow jumps straight to launch
  always_comb begin
    state_d = state_q;
    case (state_q)
      CTD_ST_IDLE: begin
        if (take) begin
          state_d = (sel == CTD_SLOT_UFLOW) ? CTD_ST_LAUNCH : CTD_ST_SAVE;
        end
      end
      CTD_ST_SAVE: begin
        state_d = CTD_ST_WRID;
      end
      CTD_ST_WRID: begin
        state_d = CTD_ST_LAUNCH;
      end
      CTD_ST_LAUNCH: begin
        state_d = CTD_ST_IDLE;
      end
      default: begin
        state_d = CTD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q <= CTD_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // strobes decode the state register; data comes from flops
  assign ctx_save_o = (state_q == CTD_ST_SAVE);
  assign id_reg_we_o = (state_q == CTD_ST_WRID);
  assign redirect_o = (state_q == CTD_ST_LAUNCH);
  assign busy_o = (state_q != CTD_ST_IDLE);
  assign uflow_direct_o = uflow_q && redirect_o;
  assign trap_cause_o = cause_q;
  assign saved_pc_o = saved_pc_q;
  assign handler_pc_o = handler_pc_q;
  assign id_reg_data_o = {24'h00_0000, cause_q.trap_id_number};
  assign current_priority_field_o = prio_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  property p_cause_stable;
    busy_o |=> !busy_o || $stable(trap_cause_o);
  endproperty
  a_cause_stable: assert property (p_cause_stable) else $error("cause changed during entry");

  property p_vector;
    take && (sel != CTD_SLOT_UFLOW) |=>
      handler_pc_o == $past(trap_vec_base_i) + (PC_W'(trap_cause_o.trap_class_number) << CTD_VEC_SHIFT);
  endproperty
  a_vector: assert property (p_vector) else $error("handler address not from class");

  property p_id_before_launch;
    take && (sel != CTD_SLOT_UFLOW) |=> ctx_save_o ##1 (id_reg_we_o && !redirect_o) ##1 redirect_o;
  endproperty
  a_id_before_launch: assert property (p_id_before_launch) else $error("id not written before redirect");

  property p_prio_frozen;
    busy_o |-> $stable(current_priority_field_o);
  endproperty
  a_prio_frozen: assert property (p_prio_frozen) else $error("priority changed by trap");

  property p_always_taken;
    (state_q == CTD_ST_IDLE) && any_src |-> trap_abort_o ##1 busy_o;
  endproperty
  a_always_taken: assert property (p_always_taken) else $error("pending trap not taken");

  property p_redirect_bound;
    trap_abort_o |=> busy_o [*1] ##[0:2] redirect_o;
  endproperty
  a_redirect_bound: assert property (p_redirect_bound) else $error("no redirect after abort");

  property p_no_reset_class;
    busy_o |-> trap_cause_o.trap_class_number != CTD_CLASS_RESET;
  endproperty
  a_no_reset_class: assert property (p_no_reset_class) else $error("reserved class raised");

  property p_this_pc;
    take && sel > CTD_SLOT_STORE && sel < CTD_SLOT_SYSCALL |=> saved_pc_o == $past(faulting_instr_pc_i);
  endproperty
  a_this_pc: assert property (p_this_pc) else $error("faulting pc not saved");

  property p_syscall;
    take && sel == CTD_SLOT_SYSCALL |=>
      saved_pc_o == $past(following_instr_pc_i) && trap_cause_o.trap_id_number == $past(service_call_imm_i);
  endproperty
  a_syscall: assert property (p_syscall) else $error("syscall pc or id wrong");

  property p_uflow_direct;
    take && sel == CTD_SLOT_UFLOW |=>
      redirect_o && uflow_direct_o && handler_pc_o == $past(uflow_handler_pc_i) ##1 !busy_o;
  endproperty
  a_uflow_direct: assert property (p_uflow_direct) else $error("underflow did not jump direct");

  property p_nmi_kept;
    nmi_ext_i && busy_o |=> pend_q[CTD_AS_NMI_EXT];
  endproperty
  a_nmi_kept: assert property (p_nmi_kept) else $error("non-maskable event lost");

  property p_one_per_entry;
    take |=> !trap_abort_o;
  endproperty
  a_one_per_entry: assert property (p_one_per_entry) else $error("two traps in one entry");

  // store error returns to the erring store, not to the instruction in progress
  property p_store_pc;
    take && sel == CTD_SLOT_STORE |=> saved_pc_o == $past(store_pc_q) && trap_cause_o.trap_id_number == 8'h03;
  endproperty
  a_store_pc: assert property (p_store_pc) else $error("store error pc or id wrong");

  property p_nmi_class;
    take && sel == CTD_SLOT_NMI |=>
      trap_cause_o.trap_class_number == 3'h7 && saved_pc_o == $past(following_instr_pc_i);
  endproperty
  a_nmi_class: assert property (p_nmi_class) else $error("non-maskable class or pc wrong");

  c_normal_entry: cover property (take && sel == CTD_SLOT_STORE ##3 redirect_o);
  c_uflow_entry: cover property (take && sel == CTD_SLOT_UFLOW ##1 uflow_direct_o);
  c_syscall_entry: cover property (take && sel == CTD_SLOT_SYSCALL);
  c_nmi_while_busy: cover property (busy_o && (nmi_ext_i || watchdog_i) ##[1:4] take && sel == CTD_SLOT_NMI);
  c_back_to_back: cover property (redirect_o ##1 take);

endmodule : ctd_trap_dispatch

// file: ctd_pkg.sv
// package: cause tables, states and carriers for the trap dispatch unit
package ctd_pkg;

  // source count and async source count
  localparam int CTD_NUM_SRC = 24;
  localparam int CTD_NUM_ASYNC = 4;
  localparam int CTD_SEL_W = 5;

  // async source positions inside the pending vector
  localparam int CTD_AS_NMI_EXT = 0;
  localparam int CTD_AS_WATCHDOG = 1;
  localparam int CTD_AS_CLK_LOSS = 2;
  localparam int CTD_AS_STORE = 3;

  // priority slots of special sources (lower slot wins)
  localparam logic [4:0] CTD_SLOT_NMI = 5'h00;
  localparam logic [4:0] CTD_SLOT_STORE = 5'h01;
  localparam logic [4:0] CTD_SLOT_UFLOW = 5'h02;
  localparam logic [4:0] CTD_SLOT_SYSCALL = 5'h17;

  // vector table stride: one handler slot is 32 bytes
  localparam int CTD_VEC_SHIFT = 5;

  // class reserved for reset, never raised
  localparam logic [2:0] CTD_CLASS_RESET = 3'h0;
  localparam logic [7:0] CTD_ID_RESET = 8'h00;

  // class per priority slot
  localparam logic [2:0] CTD_SRC_CLASS [CTD_NUM_SRC] = '{
    3'h7, 3'h4, 3'h3, 3'h4, 3'h1, 3'h1, 3'h2, 3'h1, 3'h3, 3'h3, 3'h3, 3'h3,
    3'h3, 3'h3, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h5, 3'h5, 3'h6};

  // identification number per priority slot (syscall slot is overridden)
  localparam logic [7:0] CTD_SRC_ID [CTD_NUM_SRC] = '{
    8'h00, 8'h03, 8'h04, 8'h01, 8'h04, 8'h01, 8'h01, 8'h07, 8'h01, 8'h02, 8'h03, 8'h05,
    8'h06, 8'h07, 8'h02, 8'h03, 8'h05, 8'h06, 8'h04, 8'h05, 8'h02, 8'h01, 8'h02, 8'h00};

  // entry sequencer states
  typedef enum logic [1:0] {
    CTD_ST_IDLE = 2'b00,
    CTD_ST_SAVE = 2'b01,
    CTD_ST_WRID = 2'b10,
    CTD_ST_LAUNCH = 2'b11
  } ctd_state_t;

  // synchronous trap conditions, slot 2 at bit 0 up to slot 22 at bit 20
  typedef struct packed {
    logic sticky_arith_overflow_trap;
    logic arith_overflow_trap;
    logic load_bus_error_trap;
    logic invalid_addr_trap;
    logic misalignment_trap;
    logic null_address_trap;
    logic peripheral_access_trap;
    logic write_access_trap;
    logic read_access_trap;
    logic return_depth_error_trap;
    logic context_kind_error_trap;
    logic context_list_underflow_trap;
    logic call_depth_under_trap;
    logic call_depth_over_trap;
    logic free_list_depleted_trap;
    logic global_reg_write_trap;
    logic illegal_opcode_trap;
    logic protected_instr_trap;
    logic execute_access_trap;
    logic fetch_bus_error_trap;
    logic free_list_underflow_trap;
  } ctd_sync_t;

  // two-part cause code
  typedef struct packed {
    logic [2:0] trap_class_number;
    logic [7:0] trap_id_number;
  } ctd_cause_t;

endpackage : ctd_pkg

// file: ctd_cpu_model.sv
// partner model: cpu side that takes the trap id and the handler fetch
module ctd_cpu_model
  import ctd_pkg::*;
(
  input wire logic clk, // cpu clock
  input wire logic rst_n, // async reset, active low
  input wire logic abort, // trap taken this cycle
  input wire logic id_we, // id register write strobe
  input wire logic [31:0] id_data, // id value
  input wire logic redirect, // handler fetch strobe
  input wire logic uflow_direct, // direct underflow jump
  input wire logic [31:0] handler_pc, // handler address
  output logic [31:0] id_reg_q, // trap_id_data_register contents
  output logic [31:0] fetch_pc_q, // pc fetched after redirect
  output logic ordered_q // id landed before handler fetch, or fetch is the direct underflow jump
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_seen_q, wr_seen_d, ordered_d;
  logic [31:0] id_reg_d, fetch_pc_d;

  ////////////////////////////////////////////////////////////////////////////
  // next state: a new abort forgets any earlier id write
  always_comb begin
    wr_seen_d = abort ? 1'b0 : (wr_seen_q | id_we);
    id_reg_d = id_we ? id_data : id_reg_q;
    fetch_pc_d = redirect ? handler_pc : fetch_pc_q;
    ordered_d = redirect ? (wr_seen_q | uflow_direct) : ordered_q;
  end

  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_seen_q <= 1'b0;
      id_reg_q <= 32'h0000_0000;
      fetch_pc_q <= 32'h0000_0000;
      ordered_q <= 1'b0;
    end else begin
      wr_seen_q <= wr_seen_d;
      id_reg_q <= id_reg_d;
      fetch_pc_q <= fetch_pc_d;
      ordered_q <= ordered_d;
    end
  end
endmodule : ctd_cpu_model

// file: ctd_trap_dispatch_tb.sv
// testbench for the trap dispatch unit
module ctd_trap_dispatch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ctd_pkg::*;
  localparam logic [31:0] BASE = 32'h8000_0000;
  localparam logic [31:0] FPC = 32'h0000_1230;
  localparam logic [31:0] NPC = 32'h0000_1234;
  localparam logic [31:0] SPC = 32'h0000_0abc;
  localparam logic [31:0] UPC = 32'ha000_0100;
  // expected {class, id} per sync bit, bit 0 first
  localparam logic [10:0] EXP_TBL [21] = '{11'h304, 11'h401, 11'h104, 11'h101, 11'h201, 11'h107, 11'h301,
    11'h302, 11'h303, 11'h305, 11'h306, 11'h307, 11'h102, 11'h103, 11'h105, 11'h106, 11'h204, 11'h205,
    11'h402, 11'h501, 11'h502};
  logic clk, rst_n, sc, st, abort, csave, idwe, redir, udir, busy, ordered;
  logic [2:0] nmi_src;
  logic [7:0] imm, prio_i, prio_o;
  logic [31:0] spc_o, iddata, hpc, idreg, fetch;
  ctd_sync_t sync;
  ctd_cause_t cause;
  int miscompares = 0;
  int checks_done = 0;

  ////////////////////////////////////////////////////////////////////////////
  // design and cpu-side partner
  ctd_trap_dispatch u_dut (.clk(clk), .rst_n(rst_n), .sync_trap_i(sync), .faulting_instr_pc_i(FPC),
    .following_instr_pc_i(NPC), .service_call_trap_i(sc), .service_call_imm_i(imm),
    .nmi_ext_i(nmi_src[0]), .watchdog_i(nmi_src[1]), .clk_loss_i(nmi_src[2]),
    .store_bus_error_trap_i(st), .store_err_pc_i(SPC), .trap_vec_base_i(BASE), .uflow_handler_pc_i(UPC),
    .current_priority_field_i(prio_i), .trap_abort_o(abort), .trap_cause_o(cause), .ctx_save_o(csave),
    .saved_pc_o(spc_o), .id_reg_we_o(idwe), .id_reg_data_o(iddata), .redirect_o(redir),
    .handler_pc_o(hpc), .uflow_direct_o(udir), .busy_o(busy), .current_priority_field_o(prio_o));
  ctd_cpu_model u_cpu (.clk(clk), .rst_n(rst_n), .abort(abort), .id_we(idwe), .id_data(iddata),
    .redirect(redir), .uflow_direct(udir), .handler_pc(hpc), .id_reg_q(idreg), .fetch_pc_q(fetch),
    .ordered_q(ordered));

  // clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic stop_test;
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // follows one trap entry from take to idle, called at a falling edge
  task automatic entry(input logic [10:0] c, input logic [31:0] pc, input logic uf);
    int n;
    logic [7:0] pri;
    logic [31:0] vec;
    n = 0;
    vec = BASE + (32'(c[10:8]) << 5);
    // let the abort term settle on the inputs just driven
    #1;
    while (abort !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    chk("abort", {31'h0, abort}, 32'h0000_0001);
    pri = prio_i;
    @(negedge clk);
    sync = '0;
    sc = 1'b0;
    st = 1'b0;
    nmi_src = 3'h0;
    prio_i = ~pri;
    chk("cause", {21'h0, cause}, {21'h0, c});
    chk("busy", {31'h0, busy}, 32'h0000_0001);
    if (uf) begin
      chk("direct", {30'h0, redir, udir}, 32'h0000_0003);
      chk("handler", hpc, UPC);
      @(negedge clk);
    end else begin
      chk("saved pc", spc_o, pc);
      chk("ctx save", {31'h0, csave}, 32'h0000_0001);
      chk("handler", hpc, vec);
      @(negedge clk);
      chk("prio", {24'h0, prio_o}, {24'h0, pri});
      chk("id write", {31'h0, idwe}, 32'h0000_0001);
      chk("id data", iddata, {24'h0, c[7:0]});
      @(negedge clk);
      chk("redirect", {30'h0, redir, udir}, 32'h0000_0002);
      @(negedge clk);
      chk("id register", idreg, {24'h0, c[7:0]});
    end
    chk("idle", {31'h0, busy}, 32'h0000_0000);
    chk("order", {31'h0, ordered}, 32'h0000_0001);
    chk("fetch", fetch, uf ? UPC : vec);
    // back-to-back entries leave no idle edge for the priority copy to follow a change
    prio_i = pri;
  endtask : entry

  ////////////////////////////////////////////////////////////////////////////
  // each sync condition alone, all classes 1 to 5
  task automatic t_sync_each;
    for (int i = 0; i < 21; i++) begin
      sync = ctd_sync_t'(21'h1 << i);
      entry(EXP_TBL[i], FPC, i == 0);
    end
  endtask : t_sync_each

  // service call at both ends of the immediate range
  task automatic t_syscall;
    logic [7:0] v [2] = '{8'h00, 8'hff};
    for (int i = 0; i < 2; i++) begin
      sc = 1'b1;
      imm = v[i];
      entry({3'h6, v[i]}, NPC, 1'b0);
    end
  endtask : t_syscall

  // each non-maskable source as a one-cycle pulse
  task automatic t_async;
    for (int k = 0; k < 3; k++) begin
      nmi_src = 3'h1 << k;
      @(negedge clk);
      nmi_src = 3'h0;
      entry(11'h700, NPC, 1'b0);
    end
  endtask : t_async

  // store error arrives while a load trap is in entry: must not be lost
  // an external non-maskable pulse in mid-entry is kept and beats the store error
  task automatic t_store_busy;
    sync = ctd_sync_t'(21'h1 << 18);
    st = 1'b1;
    fork
      entry(11'h402, FPC, 1'b0);
      begin
        repeat (2) @(negedge clk);
        nmi_src = 3'h1;
        @(negedge clk);
        nmi_src = 3'h0;
      end
    join
    entry(11'h700, NPC, 1'b0);
    entry(11'h403, SPC, 1'b0);
  endtask : t_store_busy

  // all sync conditions with the syscall, then clock loss with all sync: one winner per entry
  task automatic t_priority;
    sync = '1;
    sc = 1'b1;
    entry(11'h304, FPC, 1'b1);
    nmi_src = 3'h4;
    @(negedge clk);
    nmi_src = 3'h0;
    sync = '1;
    entry(11'h700, NPC, 1'b0);
  endtask : t_priority

  ////////////////////////////////////////////////////////////////////////////
  // main sequence: inputs move only at falling edges
  initial begin
    rst_n = 1'b0;
    sync = '0;
    sc = 1'b0;
    st = 1'b0;
    imm = 8'h00;
    nmi_src = 3'h0;
    prio_i = 8'h5a;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("reset cause", {21'h0, cause}, 32'h0000_0000);
    t_sync_each();
    t_syscall();
    t_async();
    t_store_busy();
    t_priority();
    stop_test();
  end

  // watchdog: the run needs about 130 cycles
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule : ctd_trap_dispatch_tb
